// ---- ctls_map.vh ----
// Constants for the clock trim and lock status block: offsets, fields, resets, timing.
// Assumes a 32-bit AHB-Lite slave decoding byte addresses on a 12-bit window.
`ifndef CTLS_MAP_VH
`define CTLS_MAP_VH

// Register byte offsets, one aligned word each.
`define CTLS_TRIM_OFS      12'h000
`define CTLS_SC_OFS        12'h004
`define CTLS_IRQ_STAT_OFS  12'h008
`define CTLS_IRQ_MASK_OFS  12'h00c

// Reset values.
`define CTLS_TRIM_RESET    8'h80
`define CTLS_SC_RESET      8'h10
`define CTLS_IRQ_RESET     3'h0

// Status and control field positions.
`define CTLS_SC_LOSS       7
`define CTLS_SC_LOCK       6
`define CTLS_SC_LOOPSRC    5
`define CTLS_SC_REFSRC     4
`define CTLS_SC_MODE_HI    3
`define CTLS_SC_MODE_LO    2
`define CTLS_SC_OSCDONE    1
`define CTLS_SC_FINE       0

// Interrupt status and mask bit positions.
`define CTLS_IRQ_LOL       0
`define CTLS_IRQ_LOCK      1
`define CTLS_IRQ_OSC       2
`define CTLS_IRQ_W         3

// Clock source select and clock mode status codes.
`define CTLS_SRC_LOOP      2'h0
`define CTLS_SRC_INT       2'h1
`define CTLS_SRC_EXT       2'h2
`define CTLS_SRC_RSVD      2'h3
`define CTLS_STAT_PLL      2'h3

// Decoded operating modes.
`define CTLS_MODE_FLL_INT  3'h0
`define CTLS_MODE_BYP_INT  3'h1
`define CTLS_MODE_LPB_INT  3'h2
`define CTLS_MODE_FLL_EXT  3'h3
`define CTLS_MODE_BYP_EXT  3'h4
`define CTLS_MODE_PLL_EXT  3'h5
`define CTLS_MODE_PBY_EXT  3'h6
`define CTLS_MODE_LPB_EXT  3'h7

// Positions in the synchronised input bundle.
`define CTLS_S_REFSEL      0
`define CTLS_S_LOOPSEL     1
`define CTLS_S_REFDIV_LO   2
`define CTLS_S_VCODIV_LO   5
`define CTLS_S_SRC_LO      9
`define CTLS_S_XREFSEL     11
`define CTLS_S_XREFEN      12
`define CTLS_S_LP          13
`define CTLS_S_STOP        14
`define CTLS_S_FLL_LOCK    15
`define CTLS_S_PLL_LOCK    16
`define CTLS_S_OSC_READY   17
`define CTLS_S_LOSSIE      18
`define CTLS_S_W           19
`define CTLS_S_RESET       19'h00001

// Timing: lock must stand this long before it is reported.
`define CTLS_CLK_PERIOD_NS 10
`define CTLS_LOCK_SETTLE_NS 160
`define CTLS_LOCK_SETTLE_CYC \
  ((`CTLS_LOCK_SETTLE_NS + `CTLS_CLK_PERIOD_NS - 1) / `CTLS_CLK_PERIOD_NS)

`endif

// ---- ctls_sync.v ----
// Two flip-flop synchroniser for a bundle of independent level signals.
// Assumes every bit is a slowly changing level; multi-bit fields may skew.
`timescale 1ns/10ps

module ctls_sync #(
  parameter          WIDTH     = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;

  // One pair of flops per bit; the first stage feeds only the second.
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;  // First stage, may go metastable.
      reg safe_reg;  // Second stage, safe to read.

      always @(posedge clk) begin
        if (!resetn) begin
          meta_reg <= RESET_VAL[i];
          safe_reg <= RESET_VAL[i];
        end else begin
          meta_reg <= async_in[i];
          safe_reg <= meta_reg;
        end
      end

      assign sync_out[i] = safe_reg;
    end
  endgenerate

endmodule

// ---- ctls_clock_trim_lock_status.v ----
// Trim and status block of a clock generator, with an AHB-Lite register slave.
// Assumes one bus clock; every generator input arrives asynchronously and is
// passed through two flip-flops before any logic looks at it.
`timescale 1ns/10ps
`include "ctls_map.vh"

module ctls_clock_trim_lock_status #(
  parameter SETTLE_CYC = `CTLS_LOCK_SETTLE_CYC  // Cycles of steady lock before report.
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire        int_ref_select,
  input  wire        pll_select,
  input  wire [2:0]  ref_divider,
  input  wire [3:0]  vco_divider,
  input  wire [1:0]  clock_source_select,
  input  wire        ext_ref_select,
  input  wire        ext_ref_clk_enable,
  input  wire        low_power_select,
  input  wire        stop_mode,
  input  wire        fll_locked,
  input  wire        pll_locked,
  input  wire        osc_ready,
  input  wire        lock_loss_irq_en,
  output reg  [7:0]  trim_value,
  output reg         fine_period_adjust,
  output reg         irq
);

  // Lock settle count, cut to the width of the 8-bit counter on purpose.
  localparam [31:0] SETTLE_W = SETTLE_CYC;
  localparam [7:0]  SETTLE_N = SETTLE_W[7:0];

  // Operating mode from source select, reference, loop select and low power.
  function [2:0] mode_of;
    input [1:0] src;
    input       refsel;
    input       loopsel;
    input       lp;
    begin
      case (src)
        `CTLS_SRC_INT: begin
          mode_of = lp ? `CTLS_MODE_LPB_INT : `CTLS_MODE_BYP_INT;
        end
        `CTLS_SRC_EXT: begin
          if (lp)
            mode_of = `CTLS_MODE_LPB_EXT;
          else
            mode_of = loopsel ? `CTLS_MODE_PBY_EXT : `CTLS_MODE_BYP_EXT;
        end
        default: begin
          // The reserved code behaves like the loop output code.
          if (refsel)
            mode_of = `CTLS_MODE_FLL_INT;
          else
            mode_of = loopsel ? `CTLS_MODE_PLL_EXT : `CTLS_MODE_FLL_EXT;
        end
      endcase
    end
  endfunction

  // Register select from a byte address; zero means unmapped.
  function [3:0] reg_hit;
    input [11:0] addr;
    begin
      reg_hit = 4'h0;
      if (addr == `CTLS_TRIM_OFS)
        reg_hit = 4'h1;
      if (addr == `CTLS_SC_OFS)
        reg_hit = 4'h2;
      if (addr == `CTLS_IRQ_STAT_OFS)
        reg_hit = 4'h4;
      if (addr == `CTLS_IRQ_MASK_OFS)
        reg_hit = 4'h8;
    end
  endfunction

  // Synchronised view of the generator inputs.
  wire [`CTLS_S_W-1:0] s_bus;

  // All generator levels cross here before use; reference select resets high.
  ctls_sync #(
    .WIDTH     (`CTLS_S_W),
    .RESET_VAL (`CTLS_S_RESET)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({lock_loss_irq_en, osc_ready, pll_locked, fll_locked, stop_mode,
                low_power_select, ext_ref_clk_enable, ext_ref_select,
                clock_source_select, vco_divider, ref_divider, pll_select,
                int_ref_select}),
    .sync_out (s_bus)
  );

  // Named slices of the synchronised bundle.
  wire       s_refsel  = s_bus[`CTLS_S_REFSEL];
  wire       s_loopsel = s_bus[`CTLS_S_LOOPSEL];
  wire [2:0] s_refdiv  = s_bus[`CTLS_S_REFDIV_LO +: 3];
  wire [3:0] s_vcodiv  = s_bus[`CTLS_S_VCODIV_LO +: 4];
  wire [1:0] s_srcsel  = s_bus[`CTLS_S_SRC_LO +: 2];
  wire       s_xrefsel = s_bus[`CTLS_S_XREFSEL];
  wire       s_xrefen  = s_bus[`CTLS_S_XREFEN];
  wire       s_lp      = s_bus[`CTLS_S_LP];
  wire       s_stop    = s_bus[`CTLS_S_STOP];
  wire       s_fll_lk  = s_bus[`CTLS_S_FLL_LOCK];
  wire       s_pll_lk  = s_bus[`CTLS_S_PLL_LOCK];
  wire       s_osc_rdy = s_bus[`CTLS_S_OSC_READY];
  wire       s_lossie  = s_bus[`CTLS_S_LOSSIE];

  // Current operating mode after synchronisation.
  wire [2:0] mode = mode_of(s_srcsel, s_refsel, s_loopsel, s_lp);

  // Mode groups used by the lock and oscillator logic.
  wire mode_int_only = (mode == `CTLS_MODE_FLL_INT) || (mode == `CTLS_MODE_BYP_INT) ||
                       (mode == `CTLS_MODE_LPB_INT);
  wire mode_fll_int  = (mode == `CTLS_MODE_FLL_INT) || (mode == `CTLS_MODE_BYP_INT);
  wire mode_pll_ext  = (mode == `CTLS_MODE_PLL_EXT) || (mode == `CTLS_MODE_PBY_EXT);
  wire mode_blp      = (mode == `CTLS_MODE_LPB_INT) || (mode == `CTLS_MODE_LPB_EXT);

  // Bus pipeline state: address phase captured for the data phase.
  reg        wr_pend_reg;  // A write's data phase is running.
  reg [3:0]  wr_hit_reg;   // Which register that write targets.

  // Software visible state.
  reg [7:0]  trim_reg;              // Coarse trim word.
  reg        fine_reg;              // Fine trim bit.
  reg        loss_reg;              // Sticky loss of lock.
  reg        lock_reg;              // Reported lock.
  reg        oscdone_reg;           // Oscillator initialised.
  reg [`CTLS_IRQ_W-1:0] ist_reg;    // Interrupt status, write one to clear.
  reg [`CTLS_IRQ_W-1:0] imask_reg;  // Interrupt mask.

  // Lock tracking.
  reg [7:0]  settle_reg;     // Cycles of steady raw lock seen.
  reg        stop_prev_reg;  // Stop level last cycle.
  reg        blp_prev_reg;   // Bypass low power last cycle.
  reg        trim_chg_reg;   // Trim changed last cycle in internal FLL mode.
  reg [4:0]  cfg_prev_reg;     // Reference select, loop select and divider.
  reg [3:0]  vcodiv_prev_reg;  // VCO divider last cycle.
  reg        oscdone_prev_reg; // Oscillator flag last cycle.

  // Address phase is real only for a selected non-idle transfer.
  wire       addr_ok = hsel && htrans[1] && hready;
  wire [3:0] rd_hit  = reg_hit(haddr[11:0]);

  // Write strobes for the data phase.
  wire wr_trim = wr_pend_reg && wr_hit_reg[0];
  wire wr_sc   = wr_pend_reg && wr_hit_reg[1];
  wire wr_ist  = wr_pend_reg && wr_hit_reg[2];
  wire wr_imsk = wr_pend_reg && wr_hit_reg[3];

  // Raw lock from whichever loop the select enables; the other is off.
  wire raw_lock = s_loopsel ? s_pll_lk : s_fll_lk;

  // Detection is off when both loops are down: bypass low power or stop.
  wire det_on = !mode_blp && !s_stop;

  // Any change that forces lock to drop until the loop settles again.
  wire cfg_change = (cfg_prev_reg != {s_refsel, s_loopsel, s_refdiv}) ||
                    (mode_pll_ext && (vcodiv_prev_reg != s_vcodiv)) ||
                    trim_chg_reg;

  // Stop entry and bypass low power entry also drop lock.
  wire drop_evt = cfg_change || (s_stop && !stop_prev_reg) ||
                  (mode_blp && !blp_prev_reg) || !det_on;

  // Lock is lost when it was reported and the raw detector falls.
  wire lol_evt = lock_reg && !raw_lock && det_on && !cfg_change;

  // External reference in use by enable or by an external mode.
  wire osc_set = s_xrefsel && (s_xrefen || !mode_int_only) && s_osc_rdy;

  // Cleared by deselecting the crystal, or internal modes without enable.
  wire osc_clr = !s_xrefsel || (mode_int_only && !s_xrefen);

  // Lock to report next cycle, for the lock register and the interrupt status.
  wire lock_next = raw_lock && det_on && !drop_evt && (settle_reg >= SETTLE_N);

  // Events that set interrupt status bits; loss of lock needs its enable.
  wire [`CTLS_IRQ_W-1:0] irq_evt;
  assign irq_evt[`CTLS_IRQ_LOL]  = lol_evt && s_lossie;
  assign irq_evt[`CTLS_IRQ_LOCK] = lock_next && !lock_reg;
  assign irq_evt[`CTLS_IRQ_OSC]  = oscdone_reg && !oscdone_prev_reg;

  // Status and control byte as software reads it.
  wire [1:0] mode_st;
  wire [7:0] sc_byte;

  // Clock mode status: the reserved source code reads as the loop output.
  assign mode_st = (s_srcsel == `CTLS_SRC_INT) ? `CTLS_SRC_INT :
                   (s_srcsel == `CTLS_SRC_EXT) ? `CTLS_SRC_EXT :
                   (s_loopsel ? `CTLS_STAT_PLL : `CTLS_SRC_LOOP);

  // Loop source and reference source come from synchronised selects.
  assign sc_byte = {loss_reg, lock_reg, s_loopsel, s_refsel, mode_st,
                    oscdone_reg, fine_reg};

  // Bus answer: ready from the first edge after reset, always OKAY, read data from a flop.
  // Reads are sampled in the address phase so hrdata stands through the
  // data phase; a read right behind a write sees the old value.
  always @(posedge clk) begin
    if (!resetn) begin
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
      hrdata      <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_hit_reg  <= 4'h0;
    end else begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= addr_ok && hwrite;
      wr_hit_reg  <= addr_ok ? rd_hit : 4'h0;
      if (addr_ok && !hwrite) begin
        // Unmapped addresses read as zero.
        case (rd_hit)
          4'h1:    hrdata <= {24'h00_0000, trim_reg};
          4'h2:    hrdata <= {24'h00_0000, sc_byte};
          4'h4:    hrdata <= {29'h0000_0000, ist_reg};
          4'h8:    hrdata <= {29'h0000_0000, imask_reg};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Trim registers; software loads factory values itself, nothing here does.
  always @(posedge clk) begin
    if (!resetn) begin
      trim_reg     <= `CTLS_TRIM_RESET;
      fine_reg     <= 1'b0;
      trim_chg_reg <= 1'b0;
    end else begin
      trim_chg_reg <= 1'b0;
      if (wr_trim) begin
        trim_reg     <= hwdata[7:0];
        // Only a changed value in an internal FLL mode disturbs lock.
        trim_chg_reg <= mode_fll_int && (hwdata[7:0] != trim_reg);
      end
      if (wr_sc) begin
        fine_reg <= hwdata[`CTLS_SC_FINE];
      end
    end
  end

  // Trim outputs to the oscillator: binary word plus one finest step.
  always @(posedge clk) begin
    if (!resetn) begin
      trim_value         <= `CTLS_TRIM_RESET;
      fine_period_adjust <= 1'b0;
    end else begin
      trim_value         <= trim_reg;
      fine_period_adjust <= fine_reg;
    end
  end

  // History of the lock inputs, for change and entry detection.
  always @(posedge clk) begin
    if (!resetn) begin
      // Matches the synchroniser reset, so release shows no false change.
      cfg_prev_reg     <= 5'h10;
      vcodiv_prev_reg  <= 4'h0;
      stop_prev_reg    <= 1'b0;
      blp_prev_reg     <= 1'b0;
      oscdone_prev_reg <= 1'b0;
    end else begin
      cfg_prev_reg     <= {s_refsel, s_loopsel, s_refdiv};
      vcodiv_prev_reg  <= s_vcodiv;
      stop_prev_reg    <= s_stop;
      blp_prev_reg     <= mode_blp;
      oscdone_prev_reg <= oscdone_reg;
    end
  end

  // Lock report: raw lock must stand SETTLE_N cycles after any drop.
  // A drop event restarts the count, so lock stays clear until relock.
  always @(posedge clk) begin
    if (!resetn) begin
      settle_reg <= 8'h00;
      lock_reg   <= 1'b0;
    end else begin
      if (drop_evt || !raw_lock) begin
        settle_reg <= 8'h00;
      end else if (settle_reg < SETTLE_N) begin
        settle_reg <= settle_reg + 8'h01;
      end
      lock_reg <= lock_next;
    end
  end

  // Sticky loss of lock: a new loss wins over a clear in the same cycle.
  always @(posedge clk) begin
    if (!resetn) begin
      loss_reg <= 1'b0;
    end else if (lol_evt) begin
      loss_reg <= 1'b1;
    end else if (wr_sc && hwdata[`CTLS_SC_LOSS] && loss_reg) begin
      loss_reg <= 1'b0;
    end
  end

  // Oscillator init flag: set when ready, clear on deselect or on enable low in an internal mode.
  always @(posedge clk) begin
    if (!resetn) begin
      oscdone_reg <= 1'b0;
    end else if (osc_set) begin
      oscdone_reg <= 1'b1;
    end else if (osc_clr) begin
      oscdone_reg <= 1'b0;
    end
  end

  // Interrupt status: write one to clear, with set winning the race.
  always @(posedge clk) begin
    if (!resetn) begin
      ist_reg   <= `CTLS_IRQ_RESET;
      imask_reg <= `CTLS_IRQ_RESET;
    end else begin
      if (wr_ist)
        ist_reg <= (ist_reg & ~hwdata[`CTLS_IRQ_W-1:0]) | irq_evt;
      else
        ist_reg <= ist_reg | irq_evt;
      if (wr_imsk)
        imask_reg <= hwdata[`CTLS_IRQ_W-1:0];
    end
  end

  // Level interrupt while any unmasked status bit is set.
  // The loss-of-lock bit also needs the live enable, so dropping the
  // enable withdraws a pending request on the edge after it crosses the synchroniser.
  always @(posedge clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_reg & imask_reg &
               {{(`CTLS_IRQ_W-1){1'b1}}, s_lossie});
    end
  end

endmodule

// ---- ctls_clock_trim_lock_status_sva.sv ----
// Checker for the clock trim and lock status block, watching its top ports.
// Assumes one clock, a synchronous active-low reset and zero-wait bus answers.
`timescale 1ns/10ps
`include "ctls_map.vh"

module ctls_lock_checker #(
  parameter SETTLE_CYC = 16  // Lock settle count, handed on from the block.
) (
  input wire        clk,
  input wire        resetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire [31:0] hrdata,
  input wire        int_ref_select,
  input wire        pll_select,
  input wire [1:0]  clock_source_select,
  input wire        low_power_select,
  input wire        stop_mode,
  input wire        fll_locked,
  input wire        pll_locked,
  input wire [7:0]  trim_value,
  input wire        fine_period_adjust,
  input wire        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  wire       take    = hsel && htrans[1] && hready;  // Transfer accepted at this edge.
  wire       rd_any  = take && !hwrite;              // Any read.
  wire       rd_sc   = rd_any && (haddr[11:0] == `CTLS_SC_OFS);
  wire       wr_trim = take && hwrite && (haddr[11:0] == `CTLS_TRIM_OFS);
  wire       wr_sc   = take && hwrite && (haddr[11:0] == `CTLS_SC_OFS);
  wire       wr_mask = take && hwrite && (haddr[11:0] == `CTLS_IRQ_MASK_OFS);
  wire       mid_src = (clock_source_select == 2'h1) || (clock_source_select == 2'h2);
  wire [1:0] exp_mode = mid_src ? clock_source_select : {2{pll_select}};  // Code 11 acts as 00.
  // Each steady reason the reported lock must be clear: stop, bypass low power or active loop unlocked.
  wire       no_lock = stop_mode || (low_power_select && mid_src) ||
                       !(pll_select ? pll_locked : fll_locked);
  reg  [2:0] up_cnt_reg;  // Cycles since reset release, saturating.
  wire       up_ok   = (up_cnt_reg == 3'h7);

  // The synchronisers reload after reset, so status checks wait a few cycles.
  always @(posedge clk) begin
    if (!resetn) begin
      up_cnt_reg <= 3'h0;
    end else if (up_cnt_reg != 3'h7) begin
      up_cnt_reg <= up_cnt_reg + 3'h1;
    end
  end

  hready_high_a: assert property ($past(resetn) |-> hreadyout)
    else $error("bus slave inserted a wait state");
  upper_zero_a: assert property (rd_any |=> (hrdata[31:8] == 24'h0))
    else $error("upper read data bits not zero");
  trim_write_a: assert property (
    wr_trim ##1 1'b1 |-> ##2 (trim_value == $past(hwdata[7:0], 2)))
    else $error("trim output does not follow written word");
  fine_write_a: assert property (
    wr_sc ##1 1'b1 |-> ##2 (fine_period_adjust == $past(hwdata[0], 2)))
    else $error("fine trim output does not follow written bit");
  irq_masked_a: assert property (
    wr_mask ##1 (hwdata[2:0] == 3'h0) |-> ##2 !irq)
    else $error("interrupt high with all sources masked");
  pll_status_a: assert property (
    (up_ok && $stable(pll_select))[*4] ##0 rd_sc |=> (hrdata[5] == $past(pll_select)))
    else $error("loop source status wrong");
  ref_status_a: assert property (
    (up_ok && $stable(int_ref_select))[*4] ##0 rd_sc |=> (hrdata[4] == $past(int_ref_select)))
    else $error("reference status wrong");
  clock_mode_a: assert property (
    (up_ok && $stable(exp_mode))[*4] ##0 rd_sc |=> (hrdata[3:2] == $past(exp_mode)))
    else $error("clock mode status wrong");
  lock_clear_a: assert property (
    (up_ok && no_lock)[*5] ##0 rd_sc |=> !hrdata[6])
    else $error("lock reported while it must be clear");
  sync_delay_a: assert property (
    (up_ok && $stable(pll_select))[*2] ##1 ($changed(pll_select) && rd_sc)
    |=> (hrdata[5] != $past(pll_select)))
    else $error("loop select seen without synchronisation");

  cover property (wr_trim);
  cover property (rd_sc ##1 hrdata[7]);
  cover property ($rose(irq));
endmodule

bind ctls_clock_trim_lock_status ctls_lock_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
  .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .int_ref_select(int_ref_select), .pll_select(pll_select),
  .clock_source_select(clock_source_select), .low_power_select(low_power_select),
  .stop_mode(stop_mode), .fll_locked(fll_locked), .pll_locked(pll_locked),
  .trim_value(trim_value), .fine_period_adjust(fine_period_adjust), .irq(irq));

// ---- ctls_clock_trim_lock_status_tb.sv ----
// Self-checking bench for the clock trim and lock status block.
// Assumes a zero-wait AHB-Lite slave whose hreadyout is fed back as hready.
`timescale 1ns/10ps
`include "ctls_map.vh"

module ctls_clock_trim_lock_status_tb;
  reg         clk, resetn, hsel, hwrite, int_ref_select, pll_select;
  reg  [31:0] haddr, hwdata, d, w;
  reg  [1:0]  htrans, clock_source_select;
  reg  [2:0]  hsize, ref_divider;
  reg  [3:0]  vco_divider, k;
  reg         ext_ref_select, ext_ref_clk_enable, low_power_select, stop_mode;
  reg         fll_locked, pll_locked, osc_ready, lock_loss_irq_en;
  reg  [1:0]  m;
  wire        hreadyout, hresp, fine_period_adjust, irq;
  wire [31:0] hrdata;
  wire [7:0]  trim_value;
  integer     fail_count, total_checks, i;

  // Short settle count keeps the relock waits brief.
  ctls_clock_trim_lock_status #(.SETTLE_CYC(8)) dut (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .int_ref_select(int_ref_select), .pll_select(pll_select), .ref_divider(ref_divider),
    .vco_divider(vco_divider), .clock_source_select(clock_source_select),
    .ext_ref_select(ext_ref_select), .ext_ref_clk_enable(ext_ref_clk_enable),
    .low_power_select(low_power_select), .stop_mode(stop_mode),
    .fll_locked(fll_locked), .pll_locked(pll_locked), .osc_ready(osc_ready),
    .lock_loss_irq_en(lock_loss_irq_en), .trim_value(trim_value),
    .fine_period_adjust(fine_period_adjust), .irq(irq));

  // Prints the verdict and stops the run.
  task end_of_test;
    begin
      if (fail_count == 0 && total_checks > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask

  // Compares one value and reports a mismatch at once.
  task check(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Waits for hready at a rising edge; a bounded wait so a stall cannot hang.
  task wait_ready;
    integer n;
    begin
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1 && n < 64) begin
        n = n + 1;
        @(posedge clk);
      end
      if (n >= 64) begin
        fail_count = fail_count + 1;
        end_of_test;
      end
    end
  endtask

  // One single-word transfer: address phase, then data phase.
  task xfer(input [11:0] a, input w, input [31:0] wd);
    begin
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready;
      d = hrdata;
    end
  endtask

  task rd_chk(input [11:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h0);
      check(d, e);
    end
  endtask

  // Lets the inputs cross the synchronisers, then reads status and control.
  task chk_sc(input integer n, input [7:0] e);
    begin
      repeat (n) @(posedge clk);
      rd_chk(`CTLS_SC_OFS, {24'h0, e});
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Overall limit on the run length.
  initial begin
    repeat (100000) @(posedge clk);
    fail_count = fail_count + 1;
    end_of_test;
  end

  initial begin
    fail_count = 0;
    total_checks = 0;
    {resetn, hsel, hwrite, haddr, hwdata, htrans} = 0;
    hsize = 3'h2;
    {ref_divider, vco_divider, clock_source_select, pll_select} = 0;
    {ext_ref_select, ext_ref_clk_enable, low_power_select, stop_mode} = 0;
    {fll_locked, pll_locked, osc_ready, lock_loss_irq_en} = 0;
    int_ref_select = 1'b1;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, an unmapped place and the outputs.
    rd_chk(`CTLS_TRIM_OFS, 32'h80);
    rd_chk(`CTLS_SC_OFS, 32'h10);
    rd_chk(`CTLS_IRQ_STAT_OFS, 32'h0);
    rd_chk(`CTLS_IRQ_MASK_OFS, 32'h0);
    rd_chk(12'h010, 32'h0);
    check({23'h0, irq, trim_value}, 32'h80);
    // Trim word at its extremes; writes elsewhere leave it alone.
    for (i = 0; i < 3; i = i + 1) begin
      w = (i == 0) ? 32'h0 : ((i == 1) ? 32'hffff_ffff : 32'h5a);
      xfer(`CTLS_TRIM_OFS, 1'b1, w);
      rd_chk(`CTLS_TRIM_OFS, {24'h0, w[7:0]});
      check({24'h0, trim_value}, {24'h0, w[7:0]});
    end
    xfer(12'h020, 1'b1, 32'h11);
    rd_chk(`CTLS_TRIM_OFS, 32'h5a);
    xfer(`CTLS_SC_OFS, 1'b1, 32'h01);
    rd_chk(`CTLS_SC_OFS, 32'h11);
    check({31'h0, fine_period_adjust}, 32'h1);
    xfer(`CTLS_SC_OFS, 1'b1, 32'h00);
    rd_chk(`CTLS_SC_OFS, 32'h10);
    // A read in the cycle of a select change still sees the old source.
    pll_select <= 1'b1;
    rd_chk(`CTLS_SC_OFS, 32'h10);
    // Every combination of loop select, reference select and source code.
    for (i = 0; i < 16; i = i + 1) begin
      k = i;
      m = (k[3:2] == 2'h1 || k[3:2] == 2'h2) ? k[3:2] : {2{k[0]}};
      pll_select <= k[0];
      int_ref_select <= k[1];
      clock_source_select <= k[3:2];
      chk_sc(4, {2'h0, k[0], k[1], m, 2'h0});
    end
    pll_select <= 1'b0;
    int_ref_select <= 1'b1;
    clock_source_select <= 2'h0;
    // Oscillator ready flag: set with crystal in use, cleared on deselect.
    ext_ref_select <= 1'b1;
    ext_ref_clk_enable <= 1'b1;
    osc_ready <= 1'b1;
    chk_sc(4, 8'h12);
    ext_ref_clk_enable <= 1'b0;
    chk_sc(4, 8'h10);
    ext_ref_clk_enable <= 1'b1;
    chk_sc(4, 8'h12);
    ext_ref_select <= 1'b0;
    chk_sc(4, 8'h10);
    rd_chk(`CTLS_IRQ_STAT_OFS, 32'h4);
    xfer(`CTLS_IRQ_STAT_OFS, 1'b1, 32'h7);
    rd_chk(`CTLS_IRQ_STAT_OFS, 32'h0);
    // Lock, then lose it with the interrupt enabled and unmasked.
    fll_locked <= 1'b1;
    chk_sc(14, 8'h50);
    rd_chk(`CTLS_IRQ_STAT_OFS, 32'h2);
    xfer(`CTLS_IRQ_MASK_OFS, 1'b1, 32'h1);
    lock_loss_irq_en <= 1'b1;
    fll_locked <= 1'b0;
    chk_sc(5, 8'h90);
    check({31'h0, irq}, 32'h1);
    xfer(`CTLS_SC_OFS, 1'b1, 32'h00);
    rd_chk(`CTLS_SC_OFS, 32'h90);
    xfer(`CTLS_SC_OFS, 1'b1, 32'h80);
    rd_chk(`CTLS_SC_OFS, 32'h10);
    xfer(`CTLS_IRQ_MASK_OFS, 1'b1, 32'h0);
    rd_chk(`CTLS_IRQ_MASK_OFS, 32'h0);
    check({31'h0, irq}, 32'h0);
    xfer(`CTLS_IRQ_MASK_OFS, 1'b1, 32'h1);
    rd_chk(`CTLS_IRQ_MASK_OFS, 32'h1);
    check({31'h0, irq}, 32'h1);
    xfer(`CTLS_IRQ_STAT_OFS, 1'b1, 32'h7);
    rd_chk(`CTLS_IRQ_STAT_OFS, 32'h0);
    check({31'h0, irq}, 32'h0);
    // Loss of lock with the enable low raises no request.
    lock_loss_irq_en <= 1'b0;
    fll_locked <= 1'b1;
    chk_sc(14, 8'h50);
    fll_locked <= 1'b0;
    chk_sc(5, 8'h90);
    rd_chk(`CTLS_IRQ_STAT_OFS, 32'h2);
    check({31'h0, irq}, 32'h0);
    xfer(`CTLS_SC_OFS, 1'b1, 32'h80);
    xfer(`CTLS_IRQ_STAT_OFS, 1'b1, 32'h7);
    // Divider and trim changes, stop and bypass low power all drop lock.
    fll_locked <= 1'b1;
    chk_sc(14, 8'h50);
    ref_divider <= 3'h1;
    chk_sc(3, 8'h10);
    chk_sc(14, 8'h50);
    xfer(`CTLS_TRIM_OFS, 1'b1, 32'h33);
    chk_sc(2, 8'h10);
    chk_sc(14, 8'h50);
    stop_mode <= 1'b1;
    chk_sc(4, 8'h10);
    stop_mode <= 1'b0;
    chk_sc(14, 8'h50);
    low_power_select <= 1'b1;
    clock_source_select <= 2'h1;
    chk_sc(4, 8'h14);
    low_power_select <= 1'b0;
    clock_source_select <= 2'h0;
    chk_sc(14, 8'h50);
    // PLL engaged external: the loop swap relocks, a VCO divider change drops it.
    pll_select <= 1'b1;
    int_ref_select <= 1'b0;
    pll_locked <= 1'b1;
    chk_sc(14, 8'h6c);
    vco_divider <= 4'h1;
    chk_sc(3, 8'h2c);
    end_of_test;
  end
endmodule
